/* File: rtl/psw_core.sv */
`timescale 1ns/1ps
`include "psw_cfg.svh"
// Contract
// - write only during chip select and strobe overlap
// - update only lanes whose byte strobes are low
// - write ends at first of select/strobe rising
// - burst clock ignored during asynchronous write
// - repeated writes: strobe gap 5ns..latency-1 clocks
// - output enable high; wait output stays released
module psw_core
  import psw_pkg::*;
#(
  parameter int ADDR_W = `PSW_ADDR_W,
  parameter int DATA_W = `PSW_DATA_W,
  parameter int DEPTH  = 256
) (
  input  wire logic                  clk_sys_in,
  input  wire logic                  srst_in,
  input  wire psw_pkg::psw_ctl_t     ctl_in,
  input  wire logic [ADDR_W-1:0]     addr_in,
  input  wire logic [DATA_W-1:0]     data_in,
  input  wire logic                  burst_clk_in,
  input  wire logic                  low_adv_mode_in,
  input  wire logic [2:0]            read_latency_in,
  input  wire logic [ADDR_W-1:0]     rd_addr_in,
  output logic      [DATA_W-1:0]     rd_data_out,
  output logic                       wait_out,
  output logic                       wait_oe_out,
  output logic                       write_done_out,
  output logic                       gap_error_out
);
  import psw_pkg::*;

  localparam int IDX_W = $clog2(DEPTH);
  localparam int WHP_MIN = `PSW_WHP_MIN_CYC;

  if (DATA_W != 16 || DEPTH < 2 || IDX_W > ADDR_W)
  begin : g_bad_params
    $error("psw_core: unsupported parameters");
  end

  // pins come from the host's domain: four flops each
  logic cs_n_s;
  logic we_n_s;
  logic ub_n_s;
  logic lb_n_s;
  logic adv_n_s;
  logic bclk_s;
  psw_sync3 u_cs  (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
                   .d_in(ctl_in.chip_select_n), .q_out(cs_n_s));
  psw_sync3 u_we  (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
                   .d_in(ctl_in.write_strobe_n), .q_out(we_n_s));
  psw_sync3 u_ub  (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
                   .d_in(ctl_in.upper_byte_strobe_n), .q_out(ub_n_s));
  psw_sync3 u_lb  (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
                   .d_in(ctl_in.lower_byte_strobe_n), .q_out(lb_n_s));
  psw_sync3 u_adv (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
                   .d_in(ctl_in.address_valid_strobe_n), .q_out(adv_n_s));
  psw_sync3 #(.RESET_VAL(1'b0)) u_bclk (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
                   .d_in(burst_clk_in), .q_out(bclk_s));

  // four flops match the synchroniser's latency, so the last cycle of a window
  // still uses the address and data that stood when the strobe rose
  logic [ADDR_W-1:0] addr_d1_r;
  logic [ADDR_W-1:0] addr_d2_r;
  logic [ADDR_W-1:0] addr_d3_r;
  logic [ADDR_W-1:0] addr_d4_r;
  logic [DATA_W-1:0] data_d1_r;
  logic [DATA_W-1:0] data_d2_r;
  logic [DATA_W-1:0] data_d3_r;
  logic [DATA_W-1:0] data_d4_r;
  always_ff @(posedge clk_sys_in)
  begin
    addr_d1_r <= addr_in;
    addr_d2_r <= addr_d1_r;
    addr_d3_r <= addr_d2_r;
    addr_d4_r <= addr_d3_r;
    data_d1_r <= data_in;
    data_d2_r <= data_d1_r;
    data_d3_r <= data_d2_r;
    data_d4_r <= data_d3_r;
  end

  // address latch: captured while advance strobe is low
  logic [ADDR_W-1:0] addr_lat_r;
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
      addr_lat_r <= '0;
    else if (!adv_n_s)
      addr_lat_r <= addr_d4_r;
  end

  wire               overlap   = !cs_n_s && !we_n_s;
  wire [ADDR_W-1:0]  eff_addr  = low_adv_mode_in ? addr_d4_r : addr_lat_r;
  wire [IDX_W-1:0]   wr_idx    = eff_addr[IDX_W-1:0];
  wire               wr_hi     = overlap && !ub_n_s;
  wire               wr_lo     = overlap && !lb_n_s;

  // storage: the burst clock plays no part in the write path
  logic [DATA_W-1:0] mem_r [DEPTH];
  always_ff @(posedge clk_sys_in)
  begin
    if (wr_hi)
      mem_r[wr_idx][15:8] <= data_d4_r[15:8];
    if (wr_lo)
      mem_r[wr_idx][7:0] <= data_d4_r[7:0];
  end

  psw_state_t state_r;
  psw_state_t state_nxt;
  logic        wait_r;
  logic [15:0] gap_cnt_r;
  logic [7:0]  run_cnt_r;
  logic [2:0]  bedge_cnt_r;
  logic        bclk_d_r;
  logic        done_r;
  logic        gerr_r;
  logic [DATA_W-1:0] rd_r;

  wire bclk_rise = bclk_s && !bclk_d_r;
  wire [2:0] gap_max = read_latency_in - 3'h1;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      PSW_IDLE:  if (overlap) state_nxt = PSW_WRITE;
      PSW_WRITE: if (!overlap) state_nxt = cs_n_s ? PSW_IDLE : PSW_GAP;
      PSW_GAP:
      begin
        if (overlap)
          state_nxt = PSW_WRITE;
        else if (cs_n_s)
          state_nxt = PSW_IDLE;
      end
      default:   state_nxt = PSW_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      state_r     <= PSW_IDLE;
      wait_r      <= 1'b0;
      gap_cnt_r   <= '0;
      run_cnt_r   <= '0;
      bedge_cnt_r <= '0;
      bclk_d_r    <= 1'b0;
      done_r      <= 1'b0;
      gerr_r      <= 1'b0;
      rd_r        <= '0;
    end
    else
    begin
      state_r  <= state_nxt;
      bclk_d_r <= bclk_s;
      rd_r     <= mem_r[rd_addr_in[IDX_W-1:0]];
      done_r   <= (state_r == PSW_WRITE) && !overlap;
      wait_r   <= 1'b0;
      if (state_r == PSW_GAP)
      begin
        gap_cnt_r <= (gap_cnt_r == 16'hFFFF) ? gap_cnt_r : gap_cnt_r + 16'h1;
        if (bclk_rise && bedge_cnt_r != 3'h7)
          bedge_cnt_r <= bedge_cnt_r + 3'h1;
      end
      else
      begin
        gap_cnt_r   <= '0;
        bedge_cnt_r <= '0;
      end
      // gap that is too short or spans latency-1 clock edges is flagged
      if (state_r == PSW_GAP && overlap)
        gerr_r <= (gap_cnt_r < 16'(WHP_MIN)) || (bedge_cnt_r >= gap_max);
      else if (cs_n_s)
        gerr_r <= 1'b0;
      // run count only observes; a long run relies on the host's wider pulse
      if (cs_n_s)
        run_cnt_r <= '0;
      else if ((state_r == PSW_WRITE) && !overlap && run_cnt_r != 8'hFF)
        run_cnt_r <= run_cnt_r + 8'h1;
    end
  end

  assign rd_data_out    = rd_r;
  assign write_done_out = done_r;
  assign gap_error_out  = gerr_r;
  // wait pin is never driven in this mode
  assign wait_out       = wait_r;
  assign wait_oe_out    = wait_r;

  overlap_start_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    (state_r == PSW_IDLE && overlap) |=> state_r == PSW_WRITE)
    else $error("write window not opened on overlap");
  end_first_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    (state_r == PSW_WRITE && !overlap) |=> (write_done_out && state_r != PSW_WRITE))
    else $error("write not ended at first rising");
  lane_mask_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    (overlap && ub_n_s) |-> !wr_hi)
    else $error("upper lane written without strobe");
  no_write_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    (!overlap) |-> !(wr_hi || wr_lo))
    else $error("write outside window");
  wait_hiz_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    !wait_oe_out)
    else $error("wait pin driven");
  low_adv_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    low_adv_mode_in |-> eff_addr == addr_d4_r)
    else $error("low-advance address not from pins");
  latch_hold_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    adv_n_s |=> $stable(addr_lat_r))
    else $error("address latch moved while strobe high");
  gap_check_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    (state_r == PSW_GAP && overlap && gap_cnt_r < 16'(WHP_MIN)) |=> gap_error_out)
    else $error("short strobe gap not flagged");
  clk_ignore_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    (state_r == PSW_WRITE && overlap && $changed(bclk_s)) |=>
      (state_r == PSW_WRITE && !write_done_out))
    else $error("burst clock affected write");
  run_count_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    cs_n_s |=> run_cnt_r == 8'h0)
    else $error("run counter not cleared");
endmodule : psw_core

/* File: rtl/psw_cfg.svh */
`ifndef PSW_CFG_SVH
`define PSW_CFG_SVH
`define PSW_CLK_PERIOD_PS   4000
`define PSW_WHP_MIN_PS      5000
`define PSW_WHP_MIN_CYC     ((`PSW_WHP_MIN_PS + `PSW_CLK_PERIOD_PS - 1) / `PSW_CLK_PERIOD_PS)
`define PSW_WLRL_MIN_BCLK   1
`define PSW_LONG_RUN_COUNT  50
`define PSW_ADDR_W          21
`define PSW_DATA_W          16
`define PSW_LAT_RESET       3'h5
`endif

/* File: rtl/psw_pkg.sv */
package psw_pkg;
  typedef struct packed {
    logic        chip_select_n;
    logic        write_strobe_n;
    logic        upper_byte_strobe_n;
    logic        lower_byte_strobe_n;
    logic        address_valid_strobe_n;
    logic        output_enable_n;
  } psw_ctl_t;
  typedef enum logic [1:0] {
    PSW_IDLE  = 2'b00,
    PSW_WRITE = 2'b01,
    PSW_GAP   = 2'b11
  } psw_state_t;
endpackage : psw_pkg

/* File: rtl/psw_sync3.sv */
`timescale 1ns/1ps
// three-stage synchroniser; output moves only when stages two and three agree
module psw_sync3 #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk_sys_in,
  input  wire logic srst_in,
  input  wire logic d_in,
  output logic      q_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic q_r;
  wire  agree = (s2_r == s3_r);
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
      q_r  <= RESET_VAL;
    end
    else
    begin
      s1_r <= d_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (agree)
        q_r <= s3_r;
    end
  end
  assign q_out = q_r;
endmodule : psw_sync3

/* File: verif/psw_host.sv */
`timescale 1ns/1ps
`include "psw_cfg.svh"
module psw_host (
  input  wire logic              clk_sys_in,
  output psw_pkg::psw_ctl_t      ctl_out,
  output logic [`PSW_ADDR_W-1:0] addr_out,
  output logic [`PSW_DATA_W-1:0] data_out,
  output logic                   burst_clk_out
);
  import psw_pkg::*;
  initial
  begin
    ctl_out       = '1;
    addr_out      = '0;
    data_out      = '0;
    burst_clk_out = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] ub_lb_n,
                    input logic we_n, input logic end_cs, input int pulses, input int rises,
                    input logic latch);
    int gap;
    // a negative count asks for a two-cycle gap, too short to be trusted
    gap = (rises < 0) ? 2 : 3 + 6 * rises;
    @(posedge clk_sys_in);
    addr_out <= `PSW_ADDR_W'(a);
    ctl_out.chip_select_n <= 1'b0;
    ctl_out.address_valid_strobe_n <= 1'b0;
    if (latch)
    begin
      repeat (3) @(posedge clk_sys_in);
      ctl_out.address_valid_strobe_n <= 1'b1;
      addr_out <= ~`PSW_ADDR_W'(a);
    end
    for (int i = 0; i < pulses; i++)
    begin
      if (i > 0)
        addr_out <= `PSW_ADDR_W'(a + i);
      data_out <= d ^ 16'(i);
      {ctl_out.upper_byte_strobe_n, ctl_out.lower_byte_strobe_n} <= ub_lb_n;
      ctl_out.write_strobe_n <= we_n;
      // 72ns low pulse; first burst edge waits over one burst period
      for (int k = 0; k < 18; k++)
      begin
        @(posedge clk_sys_in);
        burst_clk_out <= (k >= 6) && ((k / 3) % 2 == 0);
      end
      if (i == pulses - 1 && end_cs)
        ctl_out.chip_select_n <= 1'b1;
      else
        ctl_out.write_strobe_n <= 1'b1;
      if (i < pulses - 1)
        for (int k = 0; k < gap; k++)
        begin
          @(posedge clk_sys_in);
          burst_clk_out <= (k < 6 * rises) && ((k / 3) % 2 == 0);
        end
    end
    repeat (8) @(posedge clk_sys_in);
    ctl_out <= '1;
    // undriven pins must not keep showing the last value
    addr_out <= ~addr_out;
    data_out <= ~data_out;
    repeat (6) @(posedge clk_sys_in);
  endtask : wr
endmodule : psw_host

/* File: verif/psram_async_write_in_sync_mode_tb_top.sv */
`timescale 1ns/1ps
`include "psw_cfg.svh"
module psram_async_write_in_sync_mode_tb_top;
  import psw_pkg::*;
  logic                   clk_sys_in   = 1'b0;
  logic                   srst_in      = 1'b1;
  logic                   low_adv_mode = 1'b1;
  logic [2:0]             read_latency = 3'h3;
  logic [`PSW_ADDR_W-1:0] rd_addr      = '0;
  psw_ctl_t               ctl;
  logic [`PSW_ADDR_W-1:0] addr;
  logic [`PSW_DATA_W-1:0] data;
  logic [`PSW_DATA_W-1:0] rd_data;
  logic                   burst_clk;
  logic                   wait_pin;
  logic                   wait_oe;
  logic                   done;
  logic                   gap_err;
  int                     num_errors = 0;
  int                     n_tests    = 0;
  int                     n_done     = 0;
  int                     n_gap      = 0;
  int                     exp_done   = 0;
  always #2 clk_sys_in = ~clk_sys_in;
  // counting pulse cycles also catches a done pulse held too long
  always @(posedge clk_sys_in)
  begin
    n_done <= n_done + int'(done === 1'b1);
    n_gap  <= n_gap + int'(gap_err === 1'b1);
  end
  psw_host host (.clk_sys_in(clk_sys_in), .ctl_out(ctl), .addr_out(addr), .data_out(data),
                 .burst_clk_out(burst_clk));
  psw_core uut (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .ctl_in(ctl), .addr_in(addr),
    .data_in(data), .burst_clk_in(burst_clk), .low_adv_mode_in(low_adv_mode),
    .read_latency_in(read_latency), .rd_addr_in(rd_addr), .rd_data_out(rd_data),
    .wait_out(wait_pin), .wait_oe_out(wait_oe), .write_done_out(done),
    .gap_error_out(gap_err));
  task automatic summarize();
    if (num_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_chk(input logic [7:0] a, input logic [15:0] d, input logic [1:0] ln,
                        input logic we_n, input logic cs_end, input int p, input int r,
                        input logic latch, input int wins);
    host.wr(a, d, ln, we_n, cs_end, p, r, latch);
    exp_done += wins;
    for (int i = 0; i < 20 && n_done < exp_done; i++)
      @(posedge clk_sys_in);
    chk(16'(n_done), 16'(exp_done));
    if (n_done < exp_done)
      summarize();
  endtask : wr_chk
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys_in);
    rd_addr <= `PSW_ADDR_W'(a);
    repeat (2) @(posedge clk_sys_in);
    #1 chk(rd_data, exp);
  endtask : rd
  task automatic t_word();
    wr_chk(8'h10, 16'h1234, 2'b00, 1'b0, 1'b0, 1, 0, 1'b0, 1);
    rd(8'h10, 16'h1234);
    chk({14'h0, wait_pin, wait_oe}, 16'h0000);
  endtask : t_word
  task automatic t_lanes();
    wr_chk(8'h10, 16'hABCD, 2'b01, 1'b0, 1'b1, 1, 0, 1'b0, 1);
    rd(8'h10, 16'hAB34);
    wr_chk(8'h10, 16'h5678, 2'b10, 1'b0, 1'b0, 1, 0, 1'b0, 1);
    rd(8'h10, 16'hAB78);
  endtask : t_lanes
  task automatic t_no_we();
    wr_chk(8'h10, 16'h0F0F, 2'b00, 1'b1, 1'b1, 1, 0, 1'b0, 0);
    rd(8'h10, 16'hAB78);
  endtask : t_no_we
  task automatic t_gap();
    int g0;
    g0 = n_gap;
    wr_chk(8'h20, 16'h1111, 2'b00, 1'b0, 1'b0, 2, 1, 1'b0, 2);
    chk(16'(n_gap - g0), 16'h0000);
    rd(8'h21, 16'h1110);
    wr_chk(8'h20, 16'h2222, 2'b00, 1'b0, 1'b0, 2, 2, 1'b0, 2);
    chk({15'h0, n_gap > g0}, 16'h0001);
    chk({15'h0, gap_err}, 16'h0000);
    g0 = n_gap;
    wr_chk(8'h40, 16'h3333, 2'b00, 1'b0, 1'b0, 2, -1, 1'b0, 2);
    chk({15'h0, n_gap > g0}, 16'h0001);
    rd(8'h41, 16'h3332);
  endtask : t_gap
  task automatic t_reset();
    @(posedge clk_sys_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    @(posedge clk_sys_in);
    #1 chk({13'h0, done, gap_err, wait_oe}, 16'h0000);
  endtask : t_reset
  task automatic t_latch();
    @(posedge clk_sys_in);
    low_adv_mode <= 1'b0;
    wr_chk(8'h30, 16'h4321, 2'b00, 1'b0, 1'b0, 1, 0, 1'b1, 1);
    rd(8'h30, 16'h4321);
  endtask : t_latch
  initial
  begin
    repeat (2) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    t_word();
    t_lanes();
    t_no_we();
    t_gap();
    t_reset();
    t_latch();
    summarize();
  end
endmodule : psram_async_write_in_sync_mode_tb_top
